// ### rtl/lsh_defines.svh
// Offsets, field positions, reset values and timing counts of the LIN sync block.
// Assumes an APB slave with 32-bit data and a 10 MHz system clock.
`ifndef LSH_DEFINES_SVH
`define LSH_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define LSH_OFS_CTRL      8'h00
`define LSH_OFS_EDGE      8'h04
`define LSH_OFS_SYNC_TMR  8'h08
`define LSH_OFS_BRK_TMR   8'h0C
`define LSH_OFS_FLAGS     8'h10
`define LSH_OFS_DIV_LO    8'h14
`define LSH_OFS_DIV_HI    8'h18
`define LSH_OFS_DIV_FRAC  8'h1C
`define LSH_OFS_P2_DATA   8'h20
`define LSH_OFS_P2_CFG    8'h24
`define LSH_OFS_P1_CFG    8'h28
`define LSH_OFS_HV_FLAGS  8'h2C
`define LSH_OFS_HV_CFG1   8'h30
`define LSH_OFS_IRQ_EN    8'h34

// ==========================================================
// Field positions
`define LSH_CTRL_SWRST    0
`define LSH_CTRL_ENABLE   2
`define LSH_CTRL_RXGATE   8
`define LSH_FLG_BREAK     0
`define LSH_FLG_START     1
`define LSH_FLG_STOP      2
`define LSH_FLG_BRKERR    4
`define LSH_P2_READBACK   4
`define LSH_P2_DRIVE      5
`define LSH_P2CFG_GPIO    20
`define LSH_P1CFG_ALT     0
`define LSH_HV_SHORT      2
`define LSH_HV_THERMAL    3
`define LSH_HVC_PROT_DIS  2
`define LSH_HVC_DRV_EN    3
`define LSH_IRQ_EN_BIT    7

// ==========================================================
// Reset values and interrupt source mask
`define LSH_RST_EDGE      8'h32
`define LSH_RST_BRK_CMP   12'h047
`define LSH_IRQ_SRC_MASK  8'h17

// ==========================================================
// Timing
`define LSH_SYS_HZ        10000000
`define LSH_SYNC_HZ       5000000
`define LSH_BRK_HZ        131000
`define LSH_SWRST_NS      15000
`define LSH_SYS_PERIOD_NS 100
`define LSH_SYNC_DIV      (`LSH_SYS_HZ / `LSH_SYNC_HZ)
`define LSH_BRK_DIV       (`LSH_SYS_HZ / `LSH_BRK_HZ)
`define LSH_SWRST_CYC     ((`LSH_SWRST_NS + `LSH_SYS_PERIOD_NS - 1) / `LSH_SYS_PERIOD_NS)

`endif

// ### rtl/lsh_pkg.sv
// Types shared by the LIN sync block.
// Assumes the constants header is included alongside.
package lsh_pkg;

	// ==========================================================
	// Header tracking states
	typedef enum logic [1:0] {
		LSH_IDLE,
		LSH_BREAK,
		LSH_SYNC,
		LSH_DONE
	} lsh_state_type;

	// ==========================================================
	// Baud setting handed to the UART
	typedef struct packed {
		logic [15:0] frac;
		logic [7:0]  high;
		logic [7:0]  low;
	} lsh_baud_type;

endpackage : lsh_pkg

// ### rtl/lsh_top.sv
// LIN slave header synchroniser: break detect, sync timing, UART gating, pin diagnostics.
// Assumes an APB master on clk_sys, inputs synchronous to clk_sys, UART outside.
//
// Function
// - A low of at least the compare length starts a new frame.
// - Break detection runs always, also while receiving data bytes.
// - A bus stuck low is flagged as a fault.
// - Sync timed from first to fifth sync falling edge; software divides by 8.
// - Protected identifier is 6-bit id plus parity, passed to UART.
// - UART lines open only after valid break, sync and divisor setup; routed to the alternative pins, both lines pass ungated.
// - Low, high and 16-bit fractional divisors are held for the UART.
// - Break timer starts on falling edge; compare hit raises break flag.
// - Sync timer starts on start edge; edges compared with stop count.
// - At stop edge the sync timer stops and stop flag rises.
// - Live bus level readable in port 2 data bit 4.
// - GPIO select bit 20 lets software drive the bus pin.
// - Short circuit sets flag; driver re-enable clears; protection can be disabled.
// - Thermal flag never disturbs bus traffic.
// - Bit-serial frames are 19 bits at about 1200 bps; this block has no bit-serial interface.
// - Bit-serial symbols coded by low-pulse width fraction; this block decodes no bit-serial symbols.
// - Break, start, stop and break-error flags share one enabled interrupt.
// - UART lines can be routed to alternative pins.
// - Sync timer ticks at 5 MHz, independent of baud rate.
// - Break timer ticks at 131 kHz; falling edge or read clears it.
// - Break timer overflow while low raises break error.
// - Start edge count resets to 2, stop to 3; break edge is first.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "lsh_defines.svh"

module lsh_top
	import lsh_pkg::*;
#(
	parameter int BRK_DIV   = `LSH_BRK_DIV,
	parameter int SYNC_DIV  = `LSH_SYNC_DIV,
	parameter int SWRST_CYC = `LSH_SWRST_CYC
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         lin_rx,
	output logic              lin_tx,
	input  wire logic         short_detect,
	input  wire logic         thermal_event,
	input  wire logic         uart_txd,
	output logic              uart_rxd,
	output logic              uart_ready,
	output lsh_baud_type      uart_baud,
	input  wire logic         alt_rxd,
	output logic              alt_txd,
	output logic              lsh_irq
);

	// ==========================================================
	// Elaboration checks
	if (BRK_DIV < 1 || SYNC_DIV < 1 || SWRST_CYC < 1 || SWRST_CYC > 255) begin : g_chk
		$error("lsh_top: divider or reset count out of range");
	end

	// ==========================================================
	// Register address decode
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
		is_reg = (a == ofs);
	endfunction : is_reg

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= `LSH_OFS_IRQ_EN);
	endfunction : mapped

	logic               acc;
	logic               wr;
	logic               rd;
	logic               setup;
	assign acc   = psel & penable;
	assign wr    = acc & pwrite & mapped(paddr);
	assign rd    = acc & ~pwrite & mapped(paddr);
	assign setup = psel & ~penable;
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped(paddr);

	logic wr_ctrl, wr_edge, wr_brk, wr_flags, wr_lo, wr_hi, wr_frac;
	logic wr_p2d, wr_p2c, wr_p1c, wr_hvc, wr_irq, rd_brk;
	assign wr_ctrl  = wr & is_reg(paddr, `LSH_OFS_CTRL);
	assign wr_edge  = wr & is_reg(paddr, `LSH_OFS_EDGE);
	assign wr_brk   = wr & is_reg(paddr, `LSH_OFS_BRK_TMR);
	assign wr_flags = wr & is_reg(paddr, `LSH_OFS_FLAGS);
	assign wr_lo    = wr & is_reg(paddr, `LSH_OFS_DIV_LO);
	assign wr_hi    = wr & is_reg(paddr, `LSH_OFS_DIV_HI);
	assign wr_frac  = wr & is_reg(paddr, `LSH_OFS_DIV_FRAC);
	assign wr_p2d   = wr & is_reg(paddr, `LSH_OFS_P2_DATA);
	assign wr_p2c   = wr & is_reg(paddr, `LSH_OFS_P2_CFG);
	assign wr_p1c   = wr & is_reg(paddr, `LSH_OFS_P1_CFG);
	assign wr_hvc   = wr & is_reg(paddr, `LSH_OFS_HV_CFG1);
	assign wr_irq   = wr & is_reg(paddr, `LSH_OFS_IRQ_EN);
	assign rd_brk   = rd & is_reg(paddr, `LSH_OFS_BRK_TMR);

	// ==========================================================
	// Software registers
	logic [8:0]   ctrl_q;
	logic [7:0]   edge_cfg_q;
	logic [11:0]  brk_cmp_q;
	lsh_baud_type baud_q;
	logic         p2_drive_q;
	logic         p2_gpio_q;
	logic         p1_alt_q;
	logic         prot_dis_q;
	logic         irq_en_q;
	logic [7:0]   swrst_cnt_q;
	logic         swrst;
	assign swrst = (swrst_cnt_q != 8'h00);

	// Plain control storage; the reset bit self-clears after its delay
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q     <= 9'h000;
			irq_en_q   <= 1'b0;
			p2_drive_q <= 1'b1;
			p2_gpio_q  <= 1'b0;
			p1_alt_q   <= 1'b0;
			prot_dis_q <= 1'b0;
			baud_q     <= '0;
		end else begin
			if (wr_ctrl) ctrl_q <= {pwdata[8:1], 1'b0};
			if (wr_irq) irq_en_q <= pwdata[`LSH_IRQ_EN_BIT];
			if (wr_p2d) p2_drive_q <= pwdata[`LSH_P2_DRIVE];
			if (wr_p2c) p2_gpio_q <= pwdata[`LSH_P2CFG_GPIO];
			if (wr_p1c) p1_alt_q <= pwdata[`LSH_P1CFG_ALT];
			if (wr_hvc) prot_dis_q <= pwdata[`LSH_HVC_PROT_DIS];
			if (wr_lo) baud_q.low <= pwdata[7:0];
			if (wr_hi) baud_q.high <= pwdata[7:0];
			if (wr_frac) baud_q.frac <= pwdata[15:0];
		end
	end

	// Synchroniser logic reset pulse and edge setup
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			swrst_cnt_q <= 8'h00;
			edge_cfg_q  <= `LSH_RST_EDGE;
			brk_cmp_q   <= `LSH_RST_BRK_CMP;
		end else if (wr_ctrl && pwdata[`LSH_CTRL_SWRST]) begin
			swrst_cnt_q <= SWRST_CYC[7:0];
			edge_cfg_q  <= `LSH_RST_EDGE;
			brk_cmp_q   <= `LSH_RST_BRK_CMP;
		end else begin
			if (swrst) swrst_cnt_q <= swrst_cnt_q - 8'h01;
			if (wr_edge && !swrst) edge_cfg_q <= pwdata[7:0];
			if (wr_brk && !swrst) brk_cmp_q <= pwdata[11:0];
		end
	end

	// ==========================================================
	// Bus edges and time bases
	logic       bus_q;
	logic       fall;
	logic       rise;
	logic [7:0] brk_div_q;
	logic [7:0] sync_div_q;
	logic       brk_tick;
	logic       sync_tick;
	assign fall      = bus_q & ~lin_rx;
	assign rise      = ~bus_q & lin_rx;
	assign brk_tick  = (brk_div_q == BRK_DIV[7:0] - 8'h01);
	assign sync_tick = (sync_div_q == SYNC_DIV[7:0] - 8'h01);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_q      <= 1'b1;
			brk_div_q  <= 8'h00;
			sync_div_q <= 8'h00;
		end else begin
			bus_q      <= lin_rx;
			brk_div_q  <= brk_tick ? 8'h00 : brk_div_q + 8'h01;
			sync_div_q <= sync_tick ? 8'h00 : sync_div_q + 8'h01;
		end
	end

	// ==========================================================
	// Break timer, sync timer and header state
	lsh_state_type state_q;
	logic [11:0]   brk_tmr_q;
	logic [15:0]   sync_tmr_q;
	logic [3:0]    edge_cnt_q;
	logic [2:0]    div_set_q;
	logic [3:0]    edge_nxt;
	logic          enabled;
	logic          brk_hit;
	logic          brk_ovf;
	logic          hit_start;
	logic          hit_stop;
	assign enabled   = ctrl_q[`LSH_CTRL_ENABLE] & ~swrst;
	assign edge_nxt  = edge_cnt_q + 4'h1;
	assign brk_hit   = enabled & ~lin_rx & ~bus_q & brk_tick
		& (brk_tmr_q + 12'h001 == brk_cmp_q);
	assign brk_ovf   = enabled & ~lin_rx & ~bus_q & brk_tick & (brk_tmr_q == 12'hFFF);
	assign hit_start = fall & (edge_nxt == edge_cfg_q[3:0]);
	assign hit_stop  = fall & (edge_nxt == edge_cfg_q[7:4]);

	// Break timer counts while low, cleared by a falling edge or a read
	always_ff @(posedge clk_sys) begin
		if (rst || swrst) begin
			brk_tmr_q <= 12'h000;
		end else if (fall || rd_brk) begin
			brk_tmr_q <= 12'h000;
		end else if (!lin_rx && brk_tick && brk_tmr_q != 12'hFFF) begin
			brk_tmr_q <= brk_tmr_q + 12'h001;
		end
	end

	// Header sequence: break, start edge, stop edge, then hold
	always_ff @(posedge clk_sys) begin
		if (rst || swrst) begin
			state_q    <= LSH_IDLE;
			edge_cnt_q <= 4'h0;
			sync_tmr_q <= 16'h0000;
		end else if (brk_hit) begin
			state_q    <= LSH_BREAK;
			edge_cnt_q <= 4'h1;
			sync_tmr_q <= 16'h0000;
		end else begin
			case (state_q)
				LSH_BREAK: begin
					if (fall) edge_cnt_q <= edge_nxt;
					if (hit_start) state_q <= LSH_SYNC;
				end
				LSH_SYNC: begin
					if (fall) edge_cnt_q <= edge_nxt;
					if (hit_stop) begin
						state_q <= LSH_DONE;
					end else if (sync_tick && sync_tmr_q != 16'hFFFF) begin
						sync_tmr_q <= sync_tmr_q + 16'h0001;
					end
				end
				LSH_DONE: begin
					state_q <= LSH_DONE;
				end
				default: begin
					state_q <= LSH_IDLE;
				end
			endcase
		end
	end

	// Divisor writes after the header arm the UART path
	always_ff @(posedge clk_sys) begin
		if (rst || swrst || brk_hit || state_q != LSH_DONE) begin
			div_set_q <= 3'h0;
		end else begin
			div_set_q <= div_set_q | {wr_frac, wr_hi, wr_lo};
		end
	end

	// ==========================================================
	// Status flags, write one to clear, set wins
	logic [7:0] flags_q;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	assign flag_set = {3'b000, brk_ovf, 1'b0,
		(state_q == LSH_SYNC) & hit_stop,
		(state_q == LSH_BREAK) & hit_start, brk_hit};
	assign flag_clr = wr_flags ? pwdata[7:0] : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (rst || swrst) begin
			flags_q <= 8'h00;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	assign lsh_irq = irq_en_q & |(flags_q & `LSH_IRQ_SRC_MASK);

	// ==========================================================
	// High-voltage interface flags
	logic short_q;
	logic thermal_q;
	logic drv_ok;
	assign drv_ok = ~short_q;

	// Short flag blocks the driver until re-enabled; thermal is report only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			short_q   <= 1'b0;
			thermal_q <= 1'b0;
		end else begin
			if (short_detect && !prot_dis_q) short_q <= 1'b1;
			else if (wr_hvc && pwdata[`LSH_HVC_DRV_EN]) short_q <= 1'b0;
			if (thermal_event) thermal_q <= 1'b1;
			else if (wr_hvc && pwdata[`LSH_HVC_DRV_EN]) thermal_q <= 1'b0;
		end
	end

	// ==========================================================
	// UART and pin routing
	logic uart_gate;
	assign uart_ready = (state_q == LSH_DONE) & (div_set_q == 3'h7);
	assign uart_gate  = uart_ready & ctrl_q[`LSH_CTRL_RXGATE];
	assign uart_rxd   = p1_alt_q ? alt_rxd : (uart_gate ? lin_rx : 1'b1);
	assign alt_txd    = p1_alt_q ? uart_txd : 1'b1;
	assign uart_baud  = baud_q;

	// Bus drive: GPIO, else UART once allowed; released on short
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lin_tx <= 1'b1;
		end else if (!drv_ok) begin
			lin_tx <= 1'b1;
		end else if (p2_gpio_q) begin
			lin_tx <= p2_drive_q;
		end else begin
			lin_tx <= (uart_ready && !p1_alt_q) ? uart_txd : 1'b1;
		end
	end

	// ==========================================================
	// Read data, captured in the setup phase
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h0000_0000;
		case (paddr)
			`LSH_OFS_CTRL:     rdata = {23'h0, ctrl_q[8:1], swrst};
			`LSH_OFS_EDGE:     rdata = {24'h0, edge_cfg_q};
			`LSH_OFS_SYNC_TMR: rdata = {16'h0, sync_tmr_q};
			`LSH_OFS_BRK_TMR:  rdata = {20'h0, brk_tmr_q};
			`LSH_OFS_FLAGS:    rdata = {24'h0, flags_q};
			`LSH_OFS_DIV_LO:   rdata = {24'h0, baud_q.low};
			`LSH_OFS_DIV_HI:   rdata = {24'h0, baud_q.high};
			`LSH_OFS_DIV_FRAC: rdata = {16'h0, baud_q.frac};
			`LSH_OFS_P2_DATA:  rdata = {26'h0, p2_drive_q, lin_rx, 4'h0};
			`LSH_OFS_P2_CFG:   rdata = {11'h0, p2_gpio_q, 20'h0};
			`LSH_OFS_P1_CFG:   rdata = {31'h0, p1_alt_q};
			`LSH_OFS_HV_FLAGS: rdata = {28'h0, thermal_q, short_q, 2'h0};
			`LSH_OFS_HV_CFG1:  rdata = {29'h0, prot_dis_q, 2'h0};
			`LSH_OFS_IRQ_EN:   rdata = {24'h0, irq_en_q, 7'h0};
			default:           rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= rdata;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_brk_flag;
		brk_hit |=> flags_q[`LSH_FLG_BREAK] && state_q == LSH_BREAK && edge_cnt_q == 4'h1;
	endproperty
	a_brk_flag: assert property (p_brk_flag) else $error("break hit not flagged");

	property p_stop;
		(state_q == LSH_SYNC && hit_stop && !brk_hit && !swrst)
			|=> state_q == LSH_DONE && flags_q[`LSH_FLG_STOP];
	endproperty
	a_stop: assert property (p_stop) else $error("stop edge not taken");

	property p_hold;
		(state_q == LSH_DONE && !brk_hit && !swrst) |=> $stable(sync_tmr_q);
	endproperty
	a_hold: assert property (p_hold) else $error("sync timer moved after stop");

	property p_gate;
		(!uart_ready && !p1_alt_q) |-> uart_rxd == 1'b1;
	endproperty
	a_gate: assert property (p_gate) else $error("uart rx open too early");

	property p_readback;
		(setup && paddr == `LSH_OFS_P2_DATA) |=> prdata[`LSH_P2_READBACK] == $past(lin_rx);
	endproperty
	a_readback: assert property (p_readback) else $error("pin readback wrong");

	property p_gpio;
		(p2_gpio_q && !short_q) |=> lin_tx == $past(p2_drive_q) || $past(short_q) != short_q;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio drive not on pin");

	property p_short;
		(short_detect && !prot_dis_q) |=> short_q ##1 lin_tx;
	endproperty
	a_short: assert property (p_short) else $error("short not handled");

	property p_irq;
		(irq_en_q && flags_q[`LSH_FLG_BRKERR]) |-> lsh_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("shared interrupt missing");

	property p_brk_err;
		brk_ovf && !swrst && !rd_brk |=> flags_q[`LSH_FLG_BRKERR] && brk_tmr_q == 12'hFFF;
	endproperty
	a_brk_err: assert property (p_brk_err) else $error("overflow not flagged");

	property p_sync_rate;
		(state_q == LSH_SYNC && sync_tick && !fall && !brk_hit && !swrst
			&& sync_tmr_q != 16'hFFFF) |=> sync_tmr_q == $past(sync_tmr_q) + 16'h0001;
	endproperty
	a_sync_rate: assert property (p_sync_rate) else $error("sync timer tick lost");

	c_done:   cover property (state_q == LSH_SYNC ##1 state_q == LSH_DONE);
	c_brkerr: cover property (brk_ovf);
	c_ready:  cover property ($rose(uart_ready));

endmodule : lsh_top

// ### test/lsh_lin_master.sv
// LIN master node model that drives the shared single-wire bus.
// Assumes an open-drain bus with pull-up; the slave drive arrives on lin_tx.
`timescale 1ns/10ps

module lsh_lin_master #(
	parameter int BIT_CLK = 40
) (
	input  wire logic clk_sys,
	input  wire logic lin_tx,
	output logic      lin_rx
);
	logic drv_q;

	// ==========================================================
	// Wired-AND bus: a released line is pulled high
	assign lin_rx = drv_q & lin_tx;

	initial drv_q = 1'b1;

	// Hold the own drive level for a number of clock cycles
	task automatic hold(input logic lvl, input int cyc);
		drv_q <= lvl;
		repeat (cyc) @(posedge clk_sys);
	endtask : hold

	// One UART byte: start bit, LSB first, stop bit
	task automatic send_byte(input logic [7:0] b);
		hold(1'b0, BIT_CLK);
		for (int i = 0; i < 8; i++) begin
			hold(b[i], BIT_CLK);
		end
		hold(1'b1, BIT_CLK);
	endtask : send_byte

	// Header: break of 13 low bits, delimiter, sync byte
	task automatic send_header();
		hold(1'b0, 13 * BIT_CLK);
		hold(1'b1, BIT_CLK);
		send_byte(8'h55);
	endtask : send_header

	// Response: protected identifier with parity, then up to eight data bytes
	task automatic send_resp(input logic [5:0] id, input int n);
		logic [7:0] pid;
		pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
		send_byte(pid);
		for (int i = 0; i < n && i < 8; i++) begin
			send_byte(8'hA5 ^ 8'(i));
		end
	endtask : send_resp

endmodule : lsh_lin_master

// ### test/lsh_top_tb.sv
// Self-checking testbench of the LIN sync block, APB tasks plus a LIN master model.
// Assumes shortened break tick (4 clk) and software reset (10 clk) parameters.
`timescale 1ns/10ps
`include "lsh_defines.svh"

module lsh_top_tb;
	import lsh_pkg::*;
	localparam int BIT = 40;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         lin_rx;
	logic         lin_tx;
	logic         short_detect = 1'b0;
	logic         thermal_event = 1'b0;
	logic         uart_txd = 1'b1;
	logic         uart_rxd;
	logic         uart_ready;
	lsh_baud_type uart_baud;
	logic         alt_rxd = 1'b1;
	logic         alt_txd;
	logic         lsh_irq;
	int           miscompares = 0;
	int           check_count = 0;

	// ==========================================================
	// Clock, design and bus master model
	always #50 clk_sys = ~clk_sys;

	lsh_top #(.BRK_DIV(4), .SYNC_DIV(2), .SWRST_CYC(10)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lin_rx(lin_rx), .lin_tx(lin_tx), .short_detect(short_detect),
		.thermal_event(thermal_event), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
		.uart_ready(uart_ready), .uart_baud(uart_baud), .alt_rxd(alt_rxd),
		.alt_txd(alt_txd), .lsh_irq(lsh_irq)
	);

	lsh_lin_master #(.BIT_CLK(BIT)) i_m (
		.clk_sys(clk_sys), .lin_tx(lin_tx), .lin_rx(lin_rx)
	);

	// ==========================================================
	// Compare and access tasks
	task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_eq

	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
		check_count++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			miscompares++;
			$display("BAD %0t %s got %h outside %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_rng

	// One APB transfer: setup, access until pready, release, one idle edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk_eq(pready, 1'b1, "pready");
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b1, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b0, 32'h0, q, e);
		chk_eq(q, exp, "read data");
		chk_eq(e, experr, "pslverr");
	endtask : rd

	task automatic rd_rng(input logic [7:0] a, input int lo, input int hi);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b0, 32'h0, q, e);
		chk_rng(q, lo, hi, "read value");
	endtask : rd_rng

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// ==========================================================
	// Watchdog: the tests need about 25000 cycles
	initial begin
		#(60000 * 100);
		miscompares++;
		conclude();
	end

	// ==========================================================
	// Test sequence
	initial begin
		tick(12);
		rst <= 1'b0;
		tick(1);
		rd(`LSH_OFS_EDGE, 32'h32);
		rd(`LSH_OFS_P2_DATA, 32'h30);
		rd(8'h3C, 32'h0, 1'b1);
		$display("test reset_values done");
		thermal_event <= 1'b1;
		wr(`LSH_OFS_IRQ_EN, 32'h80);
		wr(`LSH_OFS_CTRL, 32'h4);
		i_m.send_header();
		rd(`LSH_OFS_FLAGS, 32'h7);
		rd(`LSH_OFS_HV_FLAGS, 32'h8);
		chk_eq(lsh_irq, 1'b1, "irq");
		rd_rng(`LSH_OFS_SYNC_TMR, BIT - 2, BIT + 2);
		uart_txd <= 1'b0;
		tick(3);
		chk_eq({uart_ready, lin_tx}, 2'b01, "gated tx");
		uart_txd <= 1'b1;
		wr(`LSH_OFS_DIV_LO, 32'h34);
		wr(`LSH_OFS_DIV_HI, 32'h12);
		wr(`LSH_OFS_DIV_FRAC, 32'hABCD);
		wr(`LSH_OFS_CTRL, 32'h104);
		chk_eq(uart_baud, 32'hABCD1234, "baud");
		uart_txd <= 1'b0;
		tick(3);
		chk_eq({uart_ready, lin_tx}, 2'b10, "open tx");
		uart_txd <= 1'b1;
		i_m.hold(1'b0, 3);
		chk_eq(uart_rxd, 1'b0, "rx path");
		i_m.hold(1'b1, BIT);
		wr(`LSH_OFS_P1_CFG, 32'h1);
		uart_txd <= 1'b0;
		alt_rxd <= 1'b0;
		tick(3);
		chk_eq({alt_txd, lin_tx, uart_rxd}, 3'b010, "alt route");
		uart_txd <= 1'b1;
		alt_rxd <= 1'b1;
		wr(`LSH_OFS_P1_CFG, 32'h0);
		i_m.send_resp(6'h3C, 8);
		rd(`LSH_OFS_FLAGS, 32'h7);
		rd_rng(`LSH_OFS_SYNC_TMR, BIT - 2, BIT + 2);
		wr(`LSH_OFS_FLAGS, 32'h17);
		rd(`LSH_OFS_FLAGS, 32'h0);
		chk_eq(lsh_irq, 1'b0, "irq clear");
		thermal_event <= 1'b0;
		wr(`LSH_OFS_HV_CFG1, 32'h8);
		wr(`LSH_OFS_HV_CFG1, 32'h0);
		$display("test header_and_uart done");
		wr(`LSH_OFS_EDGE, 32'h62);
		i_m.send_byte(8'hA5);
		i_m.send_header();
		rd(`LSH_OFS_FLAGS, 32'h7);
		rd_rng(`LSH_OFS_SYNC_TMR, 4 * BIT - 2, 4 * BIT + 2);
		chk_eq(uart_ready, 1'b0, "ready after break");
		$display("test rebreak done");
		wr(`LSH_OFS_FLAGS, 32'h17);
		i_m.hold(1'b0, 4096 * 4 + 200);
		rd(`LSH_OFS_FLAGS, 32'h11);
		rd(`LSH_OFS_BRK_TMR, 32'hFFF);
		rd_rng(`LSH_OFS_BRK_TMR, 0, 1);
		i_m.hold(1'b1, BIT);
		$display("test stuck_low done");
		wr(`LSH_OFS_P2_CFG, 32'h100000);
		wr(`LSH_OFS_P2_DATA, 32'h0);
		tick(1);
		chk_eq(lin_tx, 1'b0, "gpio drive");
		rd(`LSH_OFS_P2_DATA, 32'h0);
		short_detect <= 1'b1;
		tick(3);
		chk_eq(lin_tx, 1'b1, "short release");
		rd(`LSH_OFS_HV_FLAGS, 32'h4);
		short_detect <= 1'b0;
		wr(`LSH_OFS_HV_CFG1, 32'h8);
		rd(`LSH_OFS_HV_FLAGS, 32'h0);
		wr(`LSH_OFS_HV_CFG1, 32'h4);
		short_detect <= 1'b1;
		tick(3);
		chk_eq(lin_tx, 1'b0, "protection off");
		short_detect <= 1'b0;
		wr(`LSH_OFS_P2_DATA, 32'h20);
		wr(`LSH_OFS_P2_CFG, 32'h0);
		$display("test pins done");
		wr(`LSH_OFS_CTRL, 32'h5);
		rd(`LSH_OFS_CTRL, 32'h5);
		tick(14);
		rd(`LSH_OFS_CTRL, 32'h4);
		rd(`LSH_OFS_EDGE, 32'h32);
		rd(`LSH_OFS_SYNC_TMR, 32'h0);
		rd(`LSH_OFS_FLAGS, 32'h0);
		$display("test soft_reset done");
		conclude();
	end

endmodule : lsh_top_tb
